/* pkg/rdp_pkg.sv */
// shared constants, types and table builders for the dual-parity datapath
package rdp_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int LANES = 4;
    localparam int WORDS = 128;
    localparam int WIDX = 7;
    localparam logic [6:0] LAST_WORD_MAX = 7'h7f;
    localparam logic [7:0] WORDS_MAX = 8'h80;
    localparam logic [1:0] ADDR_LSB = 2'h0;
    localparam logic [1:0] DISK_SUM = 2'h3;

    // ------------------------------------------------------------
    // galois field constants
    // ------------------------------------------------------------
    localparam logic [8:0] GF_POLY = 9'h11d;
    localparam logic [8:0] GF_ORDER = 9'h0ff;
    localparam logic [7:0] GF_ORDER8 = 8'hff;

    typedef logic [255:0][7:0] rdp_tbl_t;
    typedef logic [WORDS-1:0][31:0] rdp_buf_t;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_SINGLE_D = 3'h0, OP_P = 3'h1, OP_Q = 3'h2, OP_UPDATE = 3'h3,
        OP_DD = 3'h4, OP_DQ = 3'h5, OP_PQ = 3'h6, OP_DP = 3'h7
    } rdp_op_t;

    typedef enum logic [2:0] {
        BK_D0 = 3'h0, BK_D1 = 3'h1, BK_D2 = 3'h2, BK_P = 3'h3, BK_Q = 3'h4
    } rdp_blk_t;

    typedef enum logic [1:0] {
        MU_A = 2'h0, MU_B = 2'h1, MU_C = 2'h2, MU_D = 2'h3
    } rdp_unit_t;

    typedef enum logic [4:0] {
        U_DONE = 5'h00, U_XL = 5'h01, U_XF = 5'h02, U_BL = 5'h03, U_BF = 5'h04,
        U_H0L = 5'h05, U_H0B = 5'h06, U_QC = 5'h07, U_QF = 5'h08, U_C2 = 5'h09,
        U_H1C = 5'h0a, U_UN = 5'h0b, U_QX = 5'h0c, U_QP = 5'h0d, U_A = 5'h0e,
        U_D = 5'h0f, U_OX = 5'h10, U_OXH2 = 5'h11, U_OH1 = 5'h12, U_OH3X = 5'h13
    } rdp_uop_t;

    typedef struct packed {
        rdp_uop_t uop;
        rdp_blk_t blk;
    } rdp_step_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // ops that fetch one word per beat from memory
    function automatic logic isRead(rdp_uop_t u);
        return u inside {U_XL, U_XF, U_BL, U_BF, U_H0L, U_QC, U_QF, U_UN, U_QX, U_QP};
    endfunction

    // ops that push one result word per beat toward memory
    function automatic logic isWrite(rdp_uop_t u);
        return u inside {U_OX, U_OXH2, U_OH1, U_OH3X};
    endfunction

    // antilog table built from the field polynomial at elaboration
    function automatic rdp_tbl_t buildAntilog();
        rdp_tbl_t t;
        logic [8:0] a;
        t = '0;
        a = 9'h001;
        for (int i = 0; i < 255; i++) begin
            t[i] = a[7:0];
            a = {a[7:0], 1'b0};
            if (a[8]) begin
                a = a ^ GF_POLY;
            end
        end
        t[255] = t[0];
        return t;
    endfunction

    function automatic rdp_tbl_t buildLog();
        rdp_tbl_t t;
        rdp_tbl_t al;
        t = '0;
        al = buildAntilog();
        for (int i = 0; i < 255; i++) begin
            t[al[i]] = 8'(i);
        end
        return t;
    endfunction

    localparam rdp_tbl_t GF_LOG = buildLog();
    localparam rdp_tbl_t GF_ALOG = buildAntilog();

endpackage

/* pkg/rdp_if.sv */
// carriers between the datapath top, its multiplier set and its output buffer
`timescale 1ns/100ps

// ------------------------------------------------------------
// multiplier request and product, all four lanes
// ------------------------------------------------------------
interface rdp_mul_if;
    logic [31:0] operand;
    rdp_pkg::rdp_unit_t unitSel;
    logic [3:0][7:0] logK;
    logic [31:0] product;
    modport ctl(output operand, unitSel, logK, input product);
    modport mul(input operand, unitSel, logK, output product);
endinterface

// ------------------------------------------------------------
// valid/ready word stream, address in the upper half
// ------------------------------------------------------------
interface rdp_stream_if;
    logic valid;
    logic ready;
    logic [63:0] data;
    modport src(output valid, data, input ready);
    modport snk(input valid, data, output ready);
endinterface

/* design/rdp_gf_mul_set.sv */
// four-unit table-based gf(2^8) multiplier set, one shared adder per byte lane
`timescale 1ns/100ps

module rdp_gf_mul_set
    import rdp_pkg::*;
(
    // request and product
    rdp_mul_if.mul mulPort
);

    // ------------------------------------------------------------
    // per lane: log lookup, one adder, modulo fold, antilog lookup
    // ------------------------------------------------------------
    // the unit select only steers which log constant feeds the adder, so the
    // four units cost one adder per lane instead of four
    always_comb begin
        logic [7:0] x;
        logic [7:0] k;
        logic [8:0] sum;
        x = '0;
        k = '0;
        sum = '0;
        mulPort.product = '0;
        for (int l = 0; l < LANES; l++) begin
            x = mulPort.operand[8*l +: 8];
            k = mulPort.logK[mulPort.unitSel];
            sum = {1'b0, GF_LOG[x]} + {1'b0, k};
            if (sum >= GF_ORDER) begin
                sum = sum - GF_ORDER;
            end
            if (x == 8'h00) begin
                mulPort.product[8*l +: 8] = 8'h00;
            end else begin
                mulPort.product[8*l +: 8] = GF_ALOG[sum[7:0]];
            end
        end
    end

endmodule

/* design/rdp_out_buffer.sv */
// two-entry valid/ready buffer on the result write path
`timescale 1ns/100ps

module rdp_out_buffer
    import rdp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // filling side and draining side
    rdp_stream_if.snk inPort,
    rdp_stream_if.src outPort
);

    typedef struct packed {
        logic [1:0][63:0] slot;
        logic rdPtr;
        logic wrPtr;
        logic [1:0] count;
    } rdp_fifo_t;

    rdp_fifo_t r;
    rdp_fifo_t n;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // honest full and empty
    // ------------------------------------------------------------
    assign inPort.ready = (r.count != 2'h2);
    assign outPort.valid = (r.count != 2'h0);
    assign outPort.data = r.slot[r.rdPtr];
    assign push = inPort.valid & inPort.ready;
    assign pop = outPort.valid & outPort.ready;

    // next state: push and pop may meet in one cycle
    always_comb begin
        n = r;
        if (push) begin
            n.slot[r.wrPtr] = inPort.data;
            n.wrPtr = ~r.wrPtr;
        end
        if (pop) begin
            n.rdPtr = ~r.rdPtr;
        end
        n.count = r.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule

/* design/rdp_datapath.sv */
// dual-parity erasure-code datapath: sequencer, block buffers, memory port
// Contract
// - each multiplier looks up the log of its data byte in a fixed table
// - log of data plus fixed log of the weight, as plain integer addition; the code folds sums of 255 and up back by 255
// - that sum addresses a fixed antilog table; its output is the product
// - a zero data byte gives a zero product, skipping the log path
// - all four multiplier units of a lane share one adder
// - xor parity: load first block, fold the rest, write out when port ready
// - single data rebuild: preload xor parity, fold survivors, write result
// - weighted parity: first block into hold 0, scale by b, back into hold 0
// - later blocks via hold 2 through c, xored with running sum, into hold 1
// - both parities: first block loads accumulator and hold 0 together
// - result writes to different addresses go out strictly one at a time
// - data plus weighted parity: write rebuilt block, copy into hold 2, finish via c
// - data plus xor parity: hold 1 xor stored weighted parity, through d, to hold 3
// - after hold 3 goes out, fold it into accumulator, then write xor parity
// - double loss: the one surviving data block into accumulator and hold 0, hold 0 scaled by b
// - double loss: fold xor parity; weighted parity to hold 2, via c, into hold 1
// - accumulator via a, xor hold 1, via d gives first lost block in hold 3
// - write hold 3, fold it into accumulator, write second block separately
// - four identical byte lanes make a 32-bit data path
// - three-bit operation select picks the flow
// - start bit launches; device clears the busy bit when the flow completes
`timescale 1ns/100ps

module rdp_datapath
    import rdp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // operation control
    input wire logic startReq,
    input wire logic [2:0] operationSelect,
    input wire logic [1:0] lostFirst,
    input wire logic [1:0] lostSecond,
    input wire logic [7:0] blockWords,
    output logic regenerateRequest,
    // block base byte addresses
    input wire logic [31:0] baseD0,
    input wire logic [31:0] baseD1,
    input wire logic [31:0] baseD2,
    input wire logic [31:0] baseP,
    input wire logic [31:0] baseQ,
    // memory read request and returned data
    output logic rdReqValid,
    output logic [31:0] rdReqAddr,
    input wire logic rdReqReady,
    input wire logic rdDataValid,
    input wire logic [31:0] rdData,
    // memory write port
    output logic wrValid,
    output logic [31:0] wrAddr,
    output logic [31:0] wrData,
    input wire logic wrReady
);

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_REQ = 3'h1, S_WAIT = 3'h2, S_EXEC = 3'h3, S_PUSH = 3'h4,
        S_FIN = 3'h5
    } rdp_state_t;

    typedef struct packed {
        rdp_state_t st;
        rdp_op_t op;
        logic [1:0] la;
        logic [1:0] lb;
        logic [WIDX-1:0] lastWord;
        logic [3:0] step;
        logic [WIDX-1:0] word;
        logic [31:0] addr;
        logic [31:0] memWord;
        logic busy;
        rdp_buf_t xacc;
        rdp_buf_t h0;
        rdp_buf_t h1;
        rdp_buf_t h2;
        rdp_buf_t h3;
    } rdp_core_t;

    rdp_core_t r;
    rdp_core_t n;
    rdp_step_t cur;
    rdp_step_t nx;
    logic [31:0] pushData;
    logic [7:0] kLog;
    logic [7:0] kDiv;

    rdp_mul_if mulBus();
    rdp_stream_if bufIn();
    rdp_stream_if bufOut();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // log of a disk weight; weights are 1, 2, 4 so the log is the index
    function automatic logic [7:0] wLog(rdp_blk_t b);
        return (b inside {BK_D0, BK_D1, BK_D2}) ? {5'h00, b} : 8'h00;
    endfunction

    // log of a field inverse
    function automatic logic [7:0] negLog(logic [7:0] l);
        return (l == 8'h00) ? 8'h00 : GF_ORDER8 - l;
    endfunction

    function automatic rdp_blk_t disk(logic [1:0] k);
        return rdp_blk_t'({1'b0, k});
    endfunction

    function automatic logic [31:0] addrOf(rdp_blk_t b, logic [WIDX-1:0] w);
        logic [31:0] base;
        case (b)
            BK_D0: base = baseD0;
            BK_D1: base = baseD1;
            BK_D2: base = baseD2;
            BK_P: base = baseP;
            BK_Q: base = baseQ;
            default: base = baseD0;
        endcase
        return base + {23'h00_0000, w, ADDR_LSB};
    endfunction

    // step program per operation; survivors worked out from the lost indices
    function automatic rdp_step_t prog(rdp_op_t op, logic [3:0] i, logic [1:0] la,
                                       logic [1:0] lb);
        rdp_step_t s [9];
        rdp_blk_t s1;
        rdp_blk_t s2;
        rdp_blk_t sd;
        s1 = (la == 2'h0) ? BK_D1 : BK_D0;
        s2 = (la == 2'h2) ? BK_D1 : BK_D2;
        sd = disk(DISK_SUM - la - lb);
        for (int j = 0; j < 9; j++) begin
            s[j] = '{U_DONE, BK_D0};
        end
        case (op)
            OP_SINGLE_D: begin
                s[0] = '{U_XL, BK_P};
                s[1] = '{U_XF, s1};
                s[2] = '{U_XF, s2};
                s[3] = '{U_OX, disk(la)};
            end
            OP_P: begin
                s[0] = '{U_XL, BK_D0};
                s[1] = '{U_XF, BK_D1};
                s[2] = '{U_XF, BK_D2};
                s[3] = '{U_OX, BK_P};
            end
            OP_Q: begin
                s[0] = '{U_H0L, BK_D0};
                s[1] = '{U_H0B, BK_D0};
                s[2] = '{U_QC, BK_D1};
                s[3] = '{U_QC, BK_D2};
                s[4] = '{U_OH1, BK_Q};
            end
            OP_UPDATE: begin
                s[0] = '{U_BL, BK_D0};
                s[1] = '{U_UN, BK_D1};
                s[2] = '{U_XF, BK_P};
                s[3] = '{U_H1C, disk(la)};
                s[4] = '{U_QX, BK_Q};
                s[5] = '{U_OX, BK_P};
                s[6] = '{U_OH3X, BK_Q};
            end
            OP_DD: begin
                s[0] = '{U_BL, sd};
                s[1] = '{U_H0B, sd};
                s[2] = '{U_XF, BK_P};
                s[3] = '{U_QC, BK_Q};
                s[4] = '{U_A, disk(lb)};
                s[5] = '{U_D, disk(la)};
                s[6] = '{U_OH3X, disk(la)};
                s[7] = '{U_OX, disk(lb)};
            end
            OP_DQ: begin
                s[0] = '{U_XL, BK_P};
                s[1] = '{U_BF, s1};
                s[2] = '{U_H0B, s1};
                s[3] = '{U_QF, s2};
                s[4] = '{U_OXH2, disk(la)};
                s[5] = '{U_C2, disk(la)};
                s[6] = '{U_OH1, BK_Q};
            end
            OP_PQ: begin
                s[0] = '{U_BL, BK_D0};
                s[1] = '{U_H0B, BK_D0};
                s[2] = '{U_QF, BK_D1};
                s[3] = '{U_QF, BK_D2};
                s[4] = '{U_OX, BK_P};
                s[5] = '{U_OH1, BK_Q};
            end
            OP_DP: begin
                s[0] = '{U_BL, s1};
                s[1] = '{U_H0B, s1};
                s[2] = '{U_QF, s2};
                s[3] = '{U_QP, BK_Q};
                s[4] = '{U_OH3X, disk(la)};
                s[5] = '{U_OX, BK_P};
            end
            default: s[0] = '{U_DONE, BK_D0};
        endcase
        return (i < 4'h9) ? s[i] : rdp_step_t'{U_DONE, BK_D0};
    endfunction

    // ------------------------------------------------------------
    // multiplier operand and weight selection
    // ------------------------------------------------------------
    // d divides by the lost weight, or by the xor of both lost weights
    always_comb begin
        cur = prog(r.op, r.step, r.la, r.lb);
        kLog = wLog(cur.blk);
        kDiv = (r.op == OP_DD) ? negLog(GF_LOG[(8'h01 << r.la) ^ (8'h01 << r.lb)]) :
            negLog({6'h00, r.la});
        mulBus.logK = {kDiv, kLog, kLog, kLog};
        mulBus.unitSel = MU_C;
        mulBus.operand = r.memWord;
        case (cur.uop)
            U_H0B: begin
                mulBus.unitSel = MU_B;
                mulBus.operand = r.h0[r.word];
            end
            U_C2: mulBus.operand = r.h2[r.word];
            U_H1C: mulBus.operand = r.h1[r.word];
            U_A: begin
                mulBus.unitSel = MU_A;
                mulBus.operand = r.xacc[r.word];
            end
            U_D: begin
                mulBus.unitSel = MU_D;
                mulBus.operand = r.h3[r.word];
            end
            U_QP: begin
                mulBus.unitSel = MU_D;
                mulBus.operand = r.h1[r.word] ^ r.memWord;
            end
            default: mulBus.unitSel = MU_C;
        endcase
    end

    rdp_gf_mul_set gfMul (
        .mulPort(mulBus)
    );

    // ------------------------------------------------------------
    // result write path through the two-entry buffer
    // ------------------------------------------------------------
    always_comb begin
        case (cur.uop)
            U_OH1: pushData = r.h1[r.word];
            U_OH3X: pushData = r.h3[r.word];
            default: pushData = r.xacc[r.word];
        endcase
    end

    assign bufIn.valid = (r.st == S_PUSH);
    assign bufIn.data = {r.addr, pushData};
    assign bufOut.ready = wrReady;
    assign wrValid = bufOut.valid;
    assign wrAddr = bufOut.data[63:32];
    assign wrData = bufOut.data[31:0];

    rdp_out_buffer outBuf (
        .mclk(mclk),
        .srst(srst),
        .inPort(bufIn),
        .outPort(bufOut)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdReqValid = (r.st == S_REQ);
    assign rdReqAddr = r.addr;
    assign regenerateRequest = r.busy;

    // ------------------------------------------------------------
    // sequencer: one word per pass, step by step
    // ------------------------------------------------------------
    // a single word in flight keeps reads and writes strictly ordered, at the
    // cost of memory throughput
    always_comb begin
        logic go;
        logic adv;
        logic [WIDX-1:0] w;
        logic [31:0] p;
        n = r;
        go = 1'b0;
        adv = 1'b0;
        w = r.word;
        p = mulBus.product;
        nx = '{U_DONE, BK_D0};
        case (r.st)
            S_IDLE: begin
                if (startReq) begin
                    n.op = rdp_op_t'(operationSelect);
                    n.la = lostFirst;
                    n.lb = lostSecond;
                    n.lastWord = (blockWords == 8'h00 || blockWords > WORDS_MAX) ?
                        LAST_WORD_MAX : WIDX'(blockWords - 8'h01);
                    n.step = 4'h0;
                    n.word = '0;
                    n.busy = 1'b1;
                    go = 1'b1;
                end
            end
            S_REQ: begin
                if (rdReqReady) begin
                    n.st = S_WAIT;
                end
            end
            S_WAIT: begin
                if (rdDataValid) begin
                    n.memWord = rdData;
                    n.st = S_EXEC;
                end
            end
            S_EXEC: begin
                adv = 1'b1;
                case (cur.uop)
                    U_XL: n.xacc[w] = r.memWord;
                    U_XF: n.xacc[w] = r.xacc[w] ^ r.memWord;
                    U_BL: begin
                        n.xacc[w] = r.memWord;
                        n.h0[w] = r.memWord;
                    end
                    U_BF: begin
                        n.xacc[w] = r.xacc[w] ^ r.memWord;
                        n.h0[w] = r.memWord;
                    end
                    U_H0L: n.h0[w] = r.memWord;
                    U_H0B: n.h0[w] = p;
                    U_QC, U_QF: begin
                        n.h2[w] = r.memWord;
                        n.h1[w] = r.h0[w] ^ p;
                        n.h0[w] = r.h0[w] ^ p;
                        if (cur.uop == U_QF) begin
                            n.xacc[w] = r.xacc[w] ^ r.memWord;
                        end
                    end
                    U_C2: n.h1[w] = r.h0[w] ^ p;
                    U_H1C: n.h1[w] = p;
                    U_UN: begin
                        n.xacc[w] = r.xacc[w] ^ r.memWord;
                        n.h1[w] = r.h0[w] ^ r.memWord;
                    end
                    U_QX: n.h3[w] = r.h1[w] ^ r.memWord;
                    U_QP: n.h3[w] = p;
                    U_A: n.h3[w] = p ^ r.h1[w];
                    U_D: n.h3[w] = p;
                    default: n.h3[w] = r.h3[w];
                endcase
            end
            S_PUSH: begin
                if (bufIn.ready) begin
                    adv = 1'b1;
                    if (cur.uop == U_OXH2) begin
                        n.h2[w] = r.xacc[w];
                    end
                    if (cur.uop == U_OH3X) begin
                        n.xacc[w] = r.xacc[w] ^ r.h3[w];
                    end
                end
            end
            S_FIN: begin
                // busy drops only once the last result has left the buffer
                if (!bufOut.valid) begin
                    n.busy = 1'b0;
                    n.st = S_IDLE;
                end
            end
            default: n.st = S_IDLE;
        endcase
        if (adv) begin
            go = 1'b1;
            if (r.word == r.lastWord) begin
                n.word = '0;
                n.step = r.step + 4'h1;
            end else begin
                n.word = r.word + 7'h01;
            end
        end
        if (go) begin
            nx = prog(n.op, n.step, n.la, n.lb);
            n.addr = addrOf(nx.blk, n.word);
            if (nx.uop == U_DONE) begin
                n.st = S_FIN;
            end else if (isRead(nx.uop)) begin
                n.st = S_REQ;
            end else if (isWrite(nx.uop)) begin
                n.st = S_PUSH;
            end else begin
                n.st = S_EXEC;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule

/* sim/rdp_datapath_asserts.sv */
// port checker for the dual-parity datapath
`timescale 1ns/100ps
module rdp_datapath_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // control
    input wire logic startReq,
    input wire logic regenerateRequest,
    // memory port
    input wire logic rdReqValid,
    input wire logic [31:0] rdReqAddr,
    input wire logic rdReqReady,
    input wire logic rdDataValid,
    input wire logic wrValid,
    input wire logic [31:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic wrReady
);
    // --------
    // port rules
    // --------
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // a taken read keeps the port quiet for the next two cycles
    sequence rdTaken; rdReqValid && rdReqReady; endsequence
    sequence rdQuiet; !rdReqValid [*2]; endsequence
    AST_BUSY_RISE: assert property (!regenerateRequest && startReq |=> regenerateRequest)
        else $error("busy late");
    AST_IDLE_QUIET: assert property (!regenerateRequest |-> !rdReqValid && !wrValid)
        else $error("idle traffic");
    AST_WR_HOLD: assert property (wrValid && !wrReady |=> wrValid && $stable({wrAddr, wrData}))
        else $error("write moved");
    AST_RD_HOLD: assert property (rdReqValid && !rdReqReady |=> rdReqValid && $stable(rdReqAddr))
        else $error("read moved");
    AST_ONE_READ: assert property (rdTaken |=> rdQuiet)
        else $error("read overlap");
    AST_RD_EXEC: assert property (rdDataValid |=> !rdReqValid)
        else $error("no exec gap");
    AST_RD_ALIGN: assert property (rdReqValid |-> rdReqAddr[1:0] == 2'h0)
        else $error("read unaligned");
    AST_WR_ALIGN: assert property (wrValid |-> wrAddr[1:0] == 2'h0)
        else $error("write unaligned");
endmodule
bind rdp_datapath rdp_datapath_asserts i_rdp_datapath_asserts (.*);

/* sim/rdp_mem_model.sv */
// memory port partner: one read in flight, stalls when slow
`timescale 1ns/100ps
module rdp_mem_model (
    // clock, reset and pacing
    input wire logic mclk,
    input wire logic srst,
    input wire logic slow,
    // read side
    input wire logic rdReqValid,
    input wire logic [31:0] rdReqAddr,
    output logic rdReqReady,
    output logic rdDataValid,
    output logic [31:0] rdData,
    // write side
    input wire logic wrValid,
    input wire logic [31:0] wrAddr,
    input wire logic [31:0] wrData,
    output logic wrReady
);
    logic [31:0] mem [0:511];
    logic pend = '0;
    logic [8:0] idx;
    logic [2:0] cnt = '0;
    // ready gaps when slow; read ready also drops while a read is pending
    assign rdReqReady = !pend && (!slow || cnt[0]);
    assign wrReady = !slow || cnt[1];
    // data line flips for one cycle once invalid, then shows the last addressed word again
    always @(posedge mclk) begin
        cnt <= cnt + 3'h1;
        rdDataValid <= srst ? '0 : pend && !rdDataValid && (!slow || cnt[2]);
        rdData <= rdDataValid ? ~rdData : mem[idx];
        if (srst || rdDataValid) begin
            pend <= '0;
        end else if (rdReqValid && rdReqReady) begin
            pend <= '1;
            idx <= rdReqAddr[10:2];
        end
        if (wrValid && wrReady && !srst) begin
            mem[wrAddr[10:2]] <= wrData;
        end
    end
endmodule

/* sim/rdp_datapath_bench.sv */
// self-checking bench for the dual-parity datapath
`timescale 1ns/100ps
module rdp_datapath_bench;
    logic mclk = '0, srst = '1, startReq = '0, slow = '0;
    logic [2:0] operationSelect = '0;
    logic [1:0] lostFirst = '0, lostSecond = '0;
    logic [7:0] blockWords = 8'h01;
    logic [31:0] baseD0 = '0, baseD1 = 32'h0000_0100, baseD2 = 32'h0000_0200;
    logic [31:0] baseP = 32'h0000_0300, baseQ = 32'h0000_0400, r = 32'h0000_0053;
    logic regenerateRequest, rdReqValid, rdReqReady, rdDataValid, wrValid, wrReady;
    logic [31:0] rdReqAddr, rdData, wrAddr, wrData;
    logic [31:0] bk [0:6][0:3];
    logic [63:0] q[$];
    int n_errors = 0, compares = 0;
    always #20 mclk = ~mclk;
    rdp_datapath i_rdp_datapath (.*);
    rdp_mem_model i_rdp_mem_model (.*);
    // --------
    // helpers
    // --------
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // lane-wise field multiply by shift and add, independent of the tables
    function automatic logic [31:0] wm(logic [31:0] a, logic [7:0] g);
        logic [31:0] p;
        p = '0;
        for (int i = 0; i < 8; i++) begin
            p ^= g[i] ? a : '0;
            a = ((a & 32'h7f7f_7f7f) << 1) ^ (((a >> 7) & 32'h0101_0101) * 32'h0000_001d);
        end
        return p;
    endfunction
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // values 5 and 6 are the updated parities, written over the old ones
    task automatic ex(int k);
        for (int w = 0; w < blockWords; w++) begin
            q.push_back({32'((k > 4 ? k - 2 : k) * 256 + w * 4), bk[k][w]});
        end
    endtask
    task automatic run(logic [2:0] o, logic [1:0] a, logic [1:0] b);
        @(negedge mclk);
        r = nx(r);
        slow = r[0];
        operationSelect = o;
        lostFirst = a;
        lostSecond = b;
        startReq = '1;
        ex(o inside {1, 6} ? 3 : o == 2 ? 4 : o == 3 ? 5 : a);
        if (o >= 3'h3) begin
            ex(o == 4 ? b : o == 7 ? 3 : o == 3 ? 6 : 4);
        end
        @(negedge mclk);
        startReq = '0;
        // a start while busy must be ignored
        for (int i = 0; regenerateRequest !== 1'b0; i++) begin
            @(negedge mclk);
            startReq = i == 3;
            if (i > 4000) begin
                n_errors++;
                tally_and_finish();
            end
        end
        chk("left", 0, q.size());
    endtask
    // each accepted write takes the oldest expected word
    always @(posedge mclk) begin
        if (wrValid === 1'b1 && wrReady === 1'b1) begin
            chk("write", q.size() > 0 ? q.pop_front() : 'x, {wrAddr, wrData});
        end
    end
    // blocks, parities and updated parities; one zero byte for the bypass
    initial begin
        for (int w = 0; w < 4; w++) begin
            for (int k = 0; k < 3; k++) begin
                r = nx(nx(nx(r)));
                bk[k][w] = r;
            end
            bk[0][0][15:8] = '0;
            bk[3][w] = bk[0][w] ^ bk[1][w] ^ bk[2][w];
            bk[4][w] = bk[0][w] ^ wm(bk[1][w], 2) ^ wm(bk[2][w], 4);
            bk[5][w] = bk[3][w] ^ bk[0][w] ^ bk[1][w];
            bk[6][w] = bk[4][w] ^ wm(bk[0][w] ^ bk[1][w], 4);
            for (int k = 0; k < 5; k++) begin
                i_rdp_mem_model.mem[k * 64 + w] = bk[k][w];
            end
        end
        repeat (6) @(negedge mclk);
        srst = '0;
        run(1, 0, 0);
        blockWords = 8'h04;
        run(0, 0, 0);
        run(0, 2, 0);
        run(1, 0, 0);
        run(2, 0, 0);
        run(6, 0, 0);
        run(4, 2, 0);
        run(4, 0, 1);
        run(5, 1, 0);
        run(7, 2, 0);
        run(3, 2, 0);
        tally_and_finish();
    end
endmodule
